// *** core/rst_seq_pkg.sv ***
// Constants shared by the reset and back-up sequencer.
package rst_seq_pkg;
   localparam int unsigned STAB_MIN_CLKS     = 120;
   localparam int unsigned STAB_MAX_CLKS     = 144;
   localparam int unsigned STAB_CLKS         = STAB_MIN_CLKS;
   localparam int unsigned MACHINE_CYCLE_CLKS = 4;
   localparam int unsigned PC_WIDTH          = 14;
   localparam int unsigned STAB_CNT_WIDTH    = 8;
   localparam int unsigned LOW_CNT_WIDTH     = 4;
   localparam logic [PC_WIDTH-1:0] PC_RESET_VALUE = 14'h0000;
   localparam logic [31:0] ADDR_CTRL         = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATUS       = 32'h0000_0004;
   localparam logic [31:0] ADDR_INSN         = 32'h0000_0008;
   localparam logic [31:0] ADDR_WAKE         = 32'h0000_000C;
   localparam int unsigned CTRL_SWRST_BIT    = 0;
   localparam int unsigned INSN_CODE_LSB     = 0;
   localparam int unsigned ST_CORE_RUN_BIT   = 0;
   localparam int unsigned ST_BACKUP_BIT     = 1;
   localparam int unsigned ST_PD_FLAG_BIT    = 2;
   localparam int unsigned ST_GLOBAL_IRQ_ENABLE_FLAG_BIT       = 3;
   localparam int unsigned ST_EXT0_IRQ_REQUEST_FLAG_BIT       = 4;
   localparam int unsigned ST_EXT1_IRQ_REQUEST_FLAG_BIT       = 5;
   localparam int unsigned ST_MON_EN_BIT     = 6;
   localparam int unsigned ST_STAB_BIT       = 7;
   localparam logic [1:0]  RESP_OKAY         = 2'b00;
   localparam logic [1:0]  RESP_SLVERR       = 2'b10;
   localparam logic [1:0]  INSN_NONE         = 2'h0;
   localparam logic [1:0]  INSN_ARM          = 2'h1;
   localparam logic [1:0]  INSN_POWER_OFF    = 2'h2;
   localparam logic [1:0]  INSN_OTHER        = 2'h3;
   typedef enum logic [1:0] {
      SEQ_RESET  = 2'b00,
      SEQ_STAB   = 2'b01,
      SEQ_RUN    = 2'b10,
      SEQ_BACKUP = 2'b11
   } seq_state_e;
endpackage

// *** core/rst_req_if.sv ***
// Reset request bundle between the source combiner and the sequencer.
`timescale 1ns/1ps
`default_nettype none
interface rst_req_if;
   logic reset_req;
   logic pin_low_long;
   modport src (output reset_req, output pin_low_long);
   modport dst (input reset_req, input pin_low_long);
endinterface
`default_nettype wire

// *** core/reset_source_combiner.sv ***
// Synchronises reset pin and monitor, merges all reset sources.
`timescale 1ns/1ps
`default_nettype none
module reset_source_combiner
   import rst_seq_pkg::*;
(
   input  wire logic  aclk,
   input  wire logic  aresetn,
   input  wire logic  reset_pin_n,
   input  wire logic  por_n,
   input  wire logic  supply_low,
   input  wire logic  supply_monitor_enable_pin,
   input  wire logic  sw_reset,
   rst_req_if.src     req
);
   logic [1:0] pin_sync_reg;
   logic [1:0] por_sync_reg;
   logic [1:0] low_sync_reg;
   logic [1:0] en_sync_reg;
   logic [LOW_CNT_WIDTH-1:0] low_cnt_reg;
   logic       req_reg;
   logic       pin_low_reg;

   // Pin and power-on stages reset to their idle level, so that no false
   // low is seen in the first cycles after reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_sync_reg <= 2'h3;
         por_sync_reg <= 2'h3;
         low_sync_reg <= 2'h0;
         en_sync_reg  <= 2'h0;
      end else begin
         pin_sync_reg <= {pin_sync_reg[0], reset_pin_n}; // [R14]
         por_sync_reg <= {por_sync_reg[0], por_n};
         low_sync_reg <= {low_sync_reg[0], supply_low};
         en_sync_reg  <= {en_sync_reg[0], supply_monitor_enable_pin};
      end
   end

   // A pin low for less than a machine cycle is treated as a glitch.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_cnt_reg <= 4'h0;
      end else if (pin_sync_reg[1]) begin
         low_cnt_reg <= 4'h0;
      end else if (low_cnt_reg != LOW_CNT_WIDTH'(MACHINE_CYCLE_CLKS)) begin
         low_cnt_reg <= low_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_low_reg <= 1'b0;
         req_reg     <= 1'b1;
      end else begin
         pin_low_reg <= (low_cnt_reg ==
                         LOW_CNT_WIDTH'(MACHINE_CYCLE_CLKS)); // [R1]
         req_reg <= (low_cnt_reg == LOW_CNT_WIDTH'(MACHINE_CYCLE_CLKS))
                  | !por_sync_reg[1] // [R7]
                  | (low_sync_reg[1] & en_sync_reg[1]) // [R8] [R9]
                  | sw_reset; // [R14]
      end
   end

   assign req.reset_req    = req_reg;
   assign req.pin_low_long = pin_low_reg;
endmodule
`default_nettype wire

// *** core/wake_sync.sv ***
// Two-stage synchroniser with rising-edge pulse for the wakeup input.
`timescale 1ns/1ps
`default_nettype none
module wake_sync (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic async_in,
   output logic      rise_pulse
);
   logic [2:0] sync_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_reg <= 3'h0;
      end else begin
         sync_reg <= {sync_reg[1:0], async_in};
      end
   end

   assign rise_pulse = sync_reg[1] & !sync_reg[2];
endmodule
`default_nettype wire

// *** core/reset_and_backup_sequencer.sv ***
// Reset, stabilisation and RAM back-up sequencer with AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] Reset pin low for one machine cycle or more causes system reset.
// [R2] After release wait 120 to 144 oscillator clocks before running.
// [R3] Reset loads program counter with zero: address zero, page zero.
// [R4] Reset clears interrupt enable, power-down and both external request flags.
// [R5] Auxiliary 2, 3 and 8-bit pointers stay undefined; software sets them.
// [R6] Undefined state after reset must be initialised by software.
// [R7] Built-in power-on reset resets the device without external pulse.
// [R8] Supply drop below threshold resets the whole device.
// [R9] Supply monitor active in run and back-up only when enable pin high.
// [R10] Back-up entered only when power-off directly follows arm instruction.
// [R11] Back-up stops oscillator, keeps RAM and reset circuitry state.
// [R12] Return from back-up starts at address zero, page zero.
// [R13] Power-down flag is 1 after wakeup, 0 after any reset.
// [R14] Reset pin synchronised; all reset sources merge into one request.
// [R15] Stabilising count restarts on any reset; release after full count.
module reset_and_backup_sequencer
   import rst_seq_pkg::*;
#(
   parameter int unsigned STAB_COUNT = STAB_CLKS
)
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                reset_pin_n,
   input  wire logic                por_n,
   input  wire logic                supply_low,
   input  wire logic                supply_monitor_enable_pin,
   input  wire logic                ext_wakeup,
   output logic                     core_reset_n,
   output logic                     osc_enable,
   output logic [PC_WIDTH-1:0]      program_counter,
   output logic                     global_irq_enable_flag,
   output logic                     ext0_irq_request_flag,
   output logic                     ext1_irq_request_flag,
   output logic                     power_down_flag,
   input  wire logic [31:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [31:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready
);
   rst_req_if  req_bus ();
   seq_state_e state_reg;
   logic [STAB_CNT_WIDTH-1:0] stab_cnt_reg;
   logic       sw_reset_reg;
   logic       armed_reg;
   logic       wake_pulse;
   logic       aw_held_reg;
   logic       w_held_reg;
   logic [31:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        wr_fire;
   logic        insn_valid;
   logic [1:0]  insn_code;
   logic [31:0] status_word;
   logic [1:0]  mon_en_sync_reg;

   // One aligned word per register, so only bits 31:2 select it.
   function automatic logic word_hit(input logic [31:0] addr,
                                     input logic [31:0] base);
      return addr[31:2] == base[31:2];
   endfunction

   // The enable pin is read back as status, so it passes its own two flops.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mon_en_sync_reg <= 2'h0;
      end else begin
         mon_en_sync_reg <= {mon_en_sync_reg[0], supply_monitor_enable_pin};
      end
   end

   reset_source_combiner u_comb (
      .aclk                      (aclk),
      .aresetn                   (aresetn),
      .reset_pin_n               (reset_pin_n),
      .por_n                     (por_n),
      .supply_low                (supply_low),
      .supply_monitor_enable_pin (supply_monitor_enable_pin),
      .sw_reset                  (sw_reset_reg),
      .req                       (req_bus)
   );

   wake_sync u_wake (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .async_in   (ext_wakeup),
      .rise_pulse (wake_pulse)
   );

   // Write channel: address and data are taken in either order.
   assign wr_fire = aw_held_reg & w_held_reg & !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         awaddr_reg    <= 32'h0000_0000;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
      end else begin
         s_axi_awready <= !aw_held_reg & !s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= !w_held_reg & !s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (word_hit(awaddr_reg, ADDR_CTRL) ||
                          word_hit(awaddr_reg, ADDR_INSN))
                         ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign insn_valid = wr_fire & wstrb_reg[0] &
                       word_hit(awaddr_reg, ADDR_INSN);
   assign insn_code  = wdata_reg[INSN_CODE_LSB +: 2];

   // Software reset pulse, only from a running core.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_reset_reg <= 1'b0;
      end else begin
         sw_reset_reg <= wr_fire & wstrb_reg[0] &
                         word_hit(awaddr_reg, ADDR_CTRL) &
                         wdata_reg[CTRL_SWRST_BIT] & (state_reg == SEQ_RUN);
      end
   end

   // Arm flag lives only for the very next instruction.
   always_ff @(posedge aclk) begin
      if (!aresetn || state_reg != SEQ_RUN) begin
         armed_reg <= 1'b0;
      end else if (insn_valid) begin
         armed_reg <= (insn_code == INSN_ARM); // [R10]
      end
   end

   // Sequencer: any request restarts the stabilising wait.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg    <= SEQ_RESET;
         stab_cnt_reg <= 8'h00;
      end else if (req_bus.reset_req) begin
         state_reg    <= SEQ_RESET; // [R14]
         stab_cnt_reg <= 8'h00; // [R15]
      end else begin
         unique case (state_reg)
            SEQ_RESET: begin
               state_reg    <= SEQ_STAB;
               stab_cnt_reg <= 8'h00;
            end
            SEQ_STAB: begin
               if (stab_cnt_reg == STAB_CNT_WIDTH'(STAB_COUNT - 1)) begin
                  state_reg <= SEQ_RUN; // [R2] [R15]
               end else begin
                  stab_cnt_reg <= stab_cnt_reg + 8'h01; // [R2]
               end
            end
            SEQ_RUN: begin
               if (insn_valid && insn_code == INSN_POWER_OFF &&
                   armed_reg) begin
                  state_reg <= SEQ_BACKUP; // [R10]
               end
            end
            SEQ_BACKUP: begin
               if (wake_pulse) begin
                  state_reg    <= SEQ_STAB; // [R12]
                  stab_cnt_reg <= 8'h00;
               end
            end
         endcase
      end
   end

   // Clock gate and core release follow the sequencer state.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_enable   <= 1'b1;
         core_reset_n <= 1'b0;
      end else begin
         osc_enable   <= (state_reg != SEQ_BACKUP); // [R11]
         core_reset_n <= (state_reg == SEQ_RUN) & !req_bus.reset_req;
      end
   end

   // Power-down flag is a warm-start marker; no reset source sets it.
   always_ff @(posedge aclk) begin
      if (!aresetn || req_bus.reset_req) begin
         power_down_flag <= 1'b0; // [R4] [R13]
      end else if (state_reg == SEQ_BACKUP && wake_pulse) begin
         power_down_flag <= 1'b1; // [R13]
      end
   end

   // Both reset and wakeup restart the core from page zero.
   // Only these outputs get defined values; pointers and other core state
   // are not held here and stay for software to initialise.
   always_ff @(posedge aclk) begin // [R5] [R6]
      if (!aresetn || state_reg != SEQ_RUN) begin
         program_counter        <= PC_RESET_VALUE; // [R3] [R12]
         global_irq_enable_flag <= 1'b0; // [R4]
         ext0_irq_request_flag  <= 1'b0; // [R4]
         ext1_irq_request_flag  <= 1'b0; // [R4]
      end
   end

   assign status_word = {24'h000000,
                         state_reg == SEQ_STAB,
                         mon_en_sync_reg[1],
                         ext1_irq_request_flag,
                         ext0_irq_request_flag,
                         global_irq_enable_flag,
                         power_down_flag,
                         state_reg == SEQ_BACKUP,
                         core_reset_n};

   // Read channel: one cycle to accept, data on the next.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid & !s_axi_arready & !s_axi_rvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr[31:2])
               ADDR_STATUS[31:2]: s_axi_rdata <= status_word;
               ADDR_CTRL[31:2],
               ADDR_INSN[31:2]:   s_axi_rdata <= 32'h0000_0000;
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/seq_monitor.sv ***
// Port-level assertions for the reset and back-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module seq_monitor
   import rst_seq_pkg::*;
#(
   parameter int unsigned STAB_COUNT = STAB_CLKS
)
(
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic                reset_pin_n,
   input wire logic                por_n,
   input wire logic                supply_low,
   input wire logic                supply_monitor_enable_pin,
   input wire logic                core_reset_n,
   input wire logic                osc_enable,
   input wire logic [PC_WIDTH-1:0] program_counter,
   input wire logic                global_irq_enable_flag,
   input wire logic                ext0_irq_request_flag,
   input wire logic                ext1_irq_request_flag,
   input wire logic                power_down_flag,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready
);
   // Cycles since the last reset source other than software reset; saturates so it never wraps.
   logic [7:0] quiet_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn || !reset_pin_n || !por_n ||
          (supply_low && supply_monitor_enable_pin))
         quiet_reg <= 8'h00;
      else if (quiet_reg != 8'hFF)
         quiet_reg <= quiet_reg + 8'h01;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence pin_low; (!reset_pin_n) [*8]; endsequence
   sequence por_low; (!por_n) [*8]; endsequence
   sequence drop_seen; (supply_low && supply_monitor_enable_pin) [*8];
   endsequence
   a_pc_at_zero: assert property (!core_reset_n |->
      program_counter == PC_RESET_VALUE) else $error("pc not zero");
   a_flags_clear: assert property (!core_reset_n |->
      !(global_irq_enable_flag || ext0_irq_request_flag ||
        ext1_irq_request_flag)) else $error("flags not clear");
   a_pin_resets: assert property (pin_low |->
      ##[0:10] !core_reset_n) else $error("pin reset missed");
   a_por_resets: assert property (por_low |->
      ##[0:10] !core_reset_n) else $error("power-on reset missed");
   a_drop_resets: assert property (drop_seen |->
      ##[0:10] !core_reset_n) else $error("supply reset missed");
   a_pd_cleared: assert property (pin_low |->
      ##[0:10] !power_down_flag) else $error("power-down flag kept");
   a_full_stab: assert property ($rose(core_reset_n) |->
      int'(quiet_reg) >= STAB_COUNT) else $error("release too early");
   a_osc_core: assert property (!osc_enable |->
      !core_reset_n) else $error("core runs without oscillator");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid) else $error("read answer dropped");
endmodule
bind reset_and_backup_sequencer seq_monitor #(.STAB_COUNT(STAB_COUNT))
   seq_monitor_inst (.aclk(aclk), .aresetn(aresetn),
   .reset_pin_n(reset_pin_n), .por_n(por_n), .supply_low(supply_low),
   .supply_monitor_enable_pin(supply_monitor_enable_pin),
   .core_reset_n(core_reset_n), .osc_enable(osc_enable),
   .program_counter(program_counter),
   .global_irq_enable_flag(global_irq_enable_flag),
   .ext0_irq_request_flag(ext0_irq_request_flag),
   .ext1_irq_request_flag(ext1_irq_request_flag),
   .power_down_flag(power_down_flag), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the reset and back-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rst_seq_pkg::*;
   localparam int STABC = 4;
   typedef struct {logic wr; logic [31:0] a; logic [31:0] d;
      logic [1:0] resp; logic [31:0] exp;} row_s;
   logic aclk = 1'h0, aresetn = 1'h0, reset_pin_n = 1'h1, por_n = 1'h1;
   logic supply_low = 1'h0, supply_monitor_enable_pin = 1'h1;
   logic ext_wakeup = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic core_reset_n, osc_enable, global_irq_enable_flag, power_down_flag;
   logic ext0_irq_request_flag, ext1_irq_request_flag, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [PC_WIDTH-1:0] program_counter;
   int fail_count = 0, n_tests = 0, cycles = 0, n;
   row_s rows [5];
   reset_and_backup_sequencer #(.STAB_COUNT(STABC))
      reset_and_backup_sequencer_inst (.*);
   initial forever #2 aclk = ~aclk;
   // The whole run needs about 300 cycles; a hang stops well after.
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         results();
      end
   end
   task automatic check_word(input logic [31:0] got, input logic [31:0] e);
      n_tests++;
      if (got !== e) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask
   task automatic check_bit(input logic got, input logic e);
      check_word({31'h0, got}, {31'h0, e});
   endtask
   task automatic results();
      $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge aclk);
   endtask
   task automatic wait_core(input logic v);
      n = 0;
      while (core_reset_n !== v && n < 200) begin
         @(posedge aclk);
         n++;
      end
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] wd);
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [31:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge aclk);
   endtask
   task automatic insn(input logic [1:0] c);
      axi_wr(ADDR_INSN, {30'h0, c});
   endtask
   initial begin
      rows = '{'{1'h0, ADDR_STATUS, 32'h0, RESP_OKAY, 32'h41},
         '{1'h0, ADDR_WAKE, 32'h0, RESP_SLVERR, 32'h0},
         '{1'h1, ADDR_WAKE, 32'h0, RESP_SLVERR, 32'h0},
         '{1'h0, 32'h10, 32'h0, RESP_SLVERR, 32'h0},
         '{1'h1, ADDR_INSN, 32'h3, RESP_OKAY, 32'h0}};
      step(10);
      check_bit(core_reset_n, 1'h0);
      check_word({18'h0, program_counter}, 32'h0);
      check_bit(global_irq_enable_flag | ext0_irq_request_flag, 1'h0);
      check_bit(ext1_irq_request_flag | power_down_flag, 1'h0);
      aresetn <= 1'h1;
      wait_core(1'h1);
      check_bit(n >= STABC && n <= STABC + 8, 1'h1);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         if (rows[i].wr) axi_wr(rows[i].a, rows[i].d);
         else axi_rd(rows[i].a);
         check_word({30'h0, r}, {30'h0, rows[i].resp});
         if (!rows[i].wr && rows[i].resp === RESP_OKAY)
            check_word(d & 32'hFF, rows[i].exp);
      end
      $display("test registers done");
      // A glitch shorter than one machine cycle must not reset.
      reset_pin_n <= 1'h0;
      step(2);
      reset_pin_n <= 1'h1;
      step(16);
      check_bit(core_reset_n, 1'h1);
      reset_pin_n <= 1'h0;
      step(16);
      check_bit(core_reset_n, 1'h0);
      reset_pin_n <= 1'h1;
      step(6);
      // Long enough for the power-on check in the monitor to see it.
      por_n <= 1'h0;
      step(10);
      por_n <= 1'h1;
      wait_core(1'h1);
      check_bit(n >= STABC + 2 && n <= STABC + 12, 1'h1);
      $display("test pin done");
      supply_monitor_enable_pin <= 1'h0;
      supply_low <= 1'h1;
      step(16);
      check_bit(core_reset_n, 1'h1);
      supply_monitor_enable_pin <= 1'h1;
      step(16);
      check_bit(core_reset_n, 1'h0);
      supply_low <= 1'h0;
      wait_core(1'h1);
      $display("test supply done");
      insn(INSN_OTHER);
      insn(INSN_POWER_OFF);
      step(4);
      check_bit(osc_enable, 1'h1);
      insn(INSN_ARM);
      insn(INSN_OTHER);
      insn(INSN_POWER_OFF);
      step(4);
      check_bit(osc_enable, 1'h1);
      insn(INSN_ARM);
      insn(INSN_POWER_OFF);
      step(4);
      check_bit(osc_enable | core_reset_n, 1'h0);
      ext_wakeup <= 1'h1;
      wait_core(1'h1);
      check_bit(osc_enable & power_down_flag, 1'h1);
      check_word({18'h0, program_counter}, 32'h0);
      ext_wakeup <= 1'h0;
      $display("test backup done");
      // Software reset straight after a wakeup, so the flag must fall.
      axi_wr(ADDR_CTRL, 32'h1);
      wait_core(1'h0);
      check_bit(core_reset_n, 1'h0);
      wait_core(1'h1);
      check_bit(power_down_flag, 1'h0);
      $display("test software reset done");
      insn(INSN_ARM);
      insn(INSN_POWER_OFF);
      step(4);
      supply_monitor_enable_pin <= 1'h0;
      supply_low <= 1'h1;
      step(16);
      check_bit(osc_enable, 1'h0);
      supply_monitor_enable_pin <= 1'h1;
      step(16);
      check_bit(osc_enable, 1'h1);
      supply_low <= 1'h0;
      wait_core(1'h1);
      check_bit(core_reset_n, 1'h1);
      check_bit(power_down_flag, 1'h0);
      $display("test supply in backup done");
      results();
   end
endmodule
`default_nettype wire
